//--- verilog/ompg_pkg.sv
// constants shared by the option memory program gate
package ompg_pkg;

   // command and data widths
   localparam int unsigned CMD_ADDR_W = 16;
   localparam int unsigned CMD_DATA_W = 32;
   localparam int unsigned WB_ADDR_W  = 8;
   localparam int unsigned WB_DATA_W  = 32;
   localparam int unsigned CNT_W      = 16;

   // command source encodings
   localparam logic [1:0] SRC_SELF   = 2'h0;
   localparam logic [1:0] SRC_SERIAL = 2'h1;
   localparam logic [1:0] SRC_DEBUG  = 2'h2;

   // life-cycle state encodings
   localparam logic [1:0] LCS_SECURE_SOFTWARE_DEVELOPMENT    = 2'h1;
   localparam logic [1:0] LCS_NONSECURE_SOFTWARE_DEVELOPMENT = 2'h2;

   // debug level encodings
   localparam logic [1:0] DBG_NONSECURE_DEBUG_LEVEL = 2'h1;
   localparam logic [1:0] DBG_FULL_DEBUG_LEVEL      = 2'h2;

   // register byte offsets
   localparam logic [7:0] REG_CTRL         = 8'h00;
   localparam logic [7:0] REG_STATUS       = 8'h04;
   localparam logic [7:0] REG_LAST_REJECT  = 8'h08;
   localparam logic [7:0] REG_ACCEPT_COUNT = 8'h0C;
   localparam logic [7:0] REG_REJECT_COUNT = 8'h10;
   localparam logic [7:0] REG_REJECT_ADDR  = 8'h14;

   // control register fields
   localparam int unsigned CTRL_GATE_EN_BIT = 0;
   localparam int unsigned CTRL_CNT_CLR_BIT = 1;
   localparam logic        CTRL_GATE_EN_RST = 1'b1;

   // status register fields
   localparam int unsigned STAT_REJECT_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT   = 1;
   localparam int unsigned STAT_LCS_LSB    = 2;
   localparam int unsigned STAT_DBG_LSB    = 4;

   // last reject register fields
   localparam int unsigned LREJ_SRC_LSB     = 0;
   localparam int unsigned LREJ_REGION_BIT  = 2;
   localparam int unsigned LREJ_ACCESS_BIT  = 3;
   localparam logic [3:0]  LREJ_RST         = 4'h0;

endpackage

//--- verilog/ompg_permit.sv
// permission decision for one option memory programming command
`timescale 1ns/1ns
module ompg_permit (
   input  wire logic       gate_en_i,
   input  wire logic [1:0] source_i,
   input  wire logic       secure_region_i,
   input  wire logic       secure_access_i,
   input  wire logic [1:0] lcs_i,
   input  wire logic [1:0] dbg_i,
   output logic            permit_o
);

   wire lcs_ssd  = (lcs_i == ompg_pkg::LCS_SECURE_SOFTWARE_DEVELOPMENT);
   wire lcs_nsd  = (lcs_i == ompg_pkg::LCS_NONSECURE_SOFTWARE_DEVELOPMENT);
   wire dbg_full = (dbg_i == ompg_pkg::DBG_FULL_DEBUG_LEVEL);
   wire dbg_ns   = (dbg_i == ompg_pkg::DBG_NONSECURE_DEBUG_LEVEL);

   wire self_ok   = secure_region_i ? secure_access_i
                                    : 1'b1;
   wire serial_ok = secure_region_i ? lcs_ssd
                                    : (lcs_ssd | lcs_nsd);
   wire debug_ok  = secure_region_i ? dbg_full
                                    : (dbg_full | dbg_ns);

   // unknown sources and a closed gate never pass
   assign permit_o = gate_en_i &
      (((source_i == ompg_pkg::SRC_SELF)   & self_ok)   |
       ((source_i == ompg_pkg::SRC_SERIAL) & serial_ok) |
       ((source_i == ompg_pkg::SRC_DEBUG)  & debug_ok));

endmodule // ompg_permit

//--- verilog/ompg_counter.sv
// saturating event counter with synchronous clear
`timescale 1ns/1ns
module ompg_counter (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          clr_i,
   input  wire logic                          inc_i,
   output logic [ompg_pkg::CNT_W-1:0]         count_o
);

   wire at_max = &count_o;

   always_ff @(posedge clk_i) begin
      if (rst_i | clr_i) begin
         count_o <= '0;
      end else if (inc_i & ~at_max) begin
         count_o <= count_o + 1'b1;
      end
   end

endmodule // ompg_counter

//--- verilog/ompg_gate.sv
// option memory program gate: checks commands, forwards or rejects them
//
// Summary of operation
// - Self-programming, secure region: passes only for a secure access.
// - Self-programming, other region: passes for any access.
// - Serial, secure region: passes only in secure_software_development.
// - Debugger, secure region: passes only at full_debug_level.
// - Debugger, other region: full_debug_level or nonsecure_debug_level.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module ompg_gate (
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   // command sources
   input  wire logic                               cmd_valid_i,
   output logic                                    cmd_ready_o,
   input  wire logic [1:0]                         cmd_source_i,
   input  wire logic                               cmd_secure_region_i,
   input  wire logic                               cmd_secure_access_i,
   input  wire logic [ompg_pkg::CMD_ADDR_W-1:0]    cmd_addr_i,
   input  wire logic [ompg_pkg::CMD_DATA_W-1:0]    cmd_wdata_i,
   output logic                                    resp_valid_o,
   output logic                                    resp_error_o,
   // device state
   input  wire logic [1:0]                         lcs_i,
   input  wire logic [1:0]                         dbg_level_i,
   // option memory sequencer
   output logic                                    seq_valid_o,
   input  wire logic                               seq_ready_i,
   output logic                                    seq_secure_region_o,
   output logic [ompg_pkg::CMD_ADDR_W-1:0]         seq_addr_o,
   output logic [ompg_pkg::CMD_DATA_W-1:0]         seq_wdata_o,
   // sticky error level
   output logic                                    error_o,
   // classic wishbone slave
   input  wire logic                               wb_cyc_i,
   input  wire logic                               wb_stb_i,
   input  wire logic                               wb_we_i,
   input  wire logic [ompg_pkg::WB_ADDR_W-1:0]     wb_adr_i,
   input  wire logic [3:0]                         wb_sel_i,
   input  wire logic [ompg_pkg::WB_DATA_W-1:0]     wb_dat_i,
   output logic [ompg_pkg::WB_DATA_W-1:0]          wb_dat_o,
   output logic                                    wb_ack_o
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CHECK,
      ST_ISSUE,
      ST_REJECT
   } ompg_state_type;

   ompg_state_type state;
   ompg_state_type next_state;

   // captured command
   logic [1:0]                       cap_source;
   logic                             cap_region;
   logic                             cap_access;
   logic [ompg_pkg::CMD_ADDR_W-1:0]  cap_addr;
   logic [ompg_pkg::CMD_DATA_W-1:0]  cap_wdata;

   // software visible state
   logic                             gate_en;
   logic                             reject_flag;
   logic [3:0]                       last_reject;
   logic [ompg_pkg::CMD_ADDR_W-1:0]  reject_addr;
   logic [ompg_pkg::CNT_W-1:0]       accept_count;
   logic [ompg_pkg::CNT_W-1:0]       reject_count;

   wire permit;
   wire cmd_take;
   wire seq_take;
   wire accept_ev;
   wire reject_ev;

   // decision on the captured command and the present device state
   ompg_permit u_permit (
      .gate_en_i       (gate_en),
      .source_i        (cap_source),
      .secure_region_i (cap_region),
      .secure_access_i (cap_access),
      .lcs_i           (lcs_i),
      .dbg_i           (dbg_level_i),
      .permit_o        (permit)
   );

   // handshake strobes on both sides
   assign cmd_take  = cmd_valid_i & cmd_ready_o;
   assign seq_take  = seq_valid_o & seq_ready_i;
   assign accept_ev = (state == ST_ISSUE) & seq_take;
   assign reject_ev = (state == ST_REJECT);

   // command sequence
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (cmd_take) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            // decides on the captured command and the live lcs_i and dbg_level_i
            if (permit) begin
               next_state = ST_ISSUE;
            end else begin
               next_state = ST_REJECT;
            end
         end
         ST_ISSUE: begin
            if (seq_take) begin
               next_state = ST_IDLE;
            end
         end
         ST_REJECT: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_source <= 2'h0;
         cap_region <= 1'b0;
         cap_access <= 1'b0;
         cap_addr   <= '0;
         cap_wdata  <= '0;
      end else if (cmd_take) begin
         cap_source <= cmd_source_i;
         cap_region <= cmd_secure_region_i;
         cap_access <= cmd_secure_access_i;
         cap_addr   <= cmd_addr_i;
         cap_wdata  <= cmd_wdata_i;
      end
   end

   // source side handshake, all registered
   // ready returns with the answer: one command in flight at a time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_ready_o  <= 1'b0;
         resp_valid_o <= 1'b0;
         resp_error_o <= 1'b0;
      end else begin
         cmd_ready_o  <= (next_state == ST_IDLE) & ~cmd_take;
         resp_valid_o <= accept_ev | reject_ev;
         resp_error_o <= reject_ev;
      end
   end

   // sequencer side: only permitted commands are ever presented
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_valid_o         <= 1'b0;
         seq_secure_region_o <= 1'b0;
         seq_addr_o          <= '0;
         seq_wdata_o         <= '0;
      end else begin
         seq_valid_o <= (next_state == ST_ISSUE);
         if ((state == ST_CHECK) & permit) begin
            seq_secure_region_o <= cap_region;
            seq_addr_o          <= cap_addr;
            seq_wdata_o         <= cap_wdata;
         end
      end
   end

   // event counters
   wire cnt_clr;

   ompg_counter u_accept_cnt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clr_i   (cnt_clr),
      .inc_i   (accept_ev),
      .count_o (accept_count)
   );

   ompg_counter u_reject_cnt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clr_i   (cnt_clr),
      .inc_i   (reject_ev),
      .count_o (reject_count)
   );

   // register bus decode
   wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
   wire        hit_ctrl = (wb_adr_i == ompg_pkg::REG_CTRL);
   wire        hit_stat = (wb_adr_i == ompg_pkg::REG_STATUS);
   wire        hit_lrej = (wb_adr_i == ompg_pkg::REG_LAST_REJECT);
   wire        hit_acnt = (wb_adr_i == ompg_pkg::REG_ACCEPT_COUNT);
   wire        hit_rcnt = (wb_adr_i == ompg_pkg::REG_REJECT_COUNT);
   wire        hit_radr = (wb_adr_i == ompg_pkg::REG_REJECT_ADDR);
   wire        wr_ctrl  = wb_wr & hit_ctrl;
   wire        wr_stat  = wb_wr & hit_stat;
   wire        clr_rej  = wr_stat & wb_dat_i[ompg_pkg::STAT_REJECT_BIT];

   assign cnt_clr = wr_ctrl & wb_dat_i[ompg_pkg::CTRL_CNT_CLR_BIT];

   // read words: each field sits at its named bit position
   logic [31:0] rd_ctrl;
   logic [31:0] rd_stat;
   wire         busy = (state != ST_IDLE);

   always_comb begin
      rd_ctrl = 32'h0;
      rd_ctrl[ompg_pkg::CTRL_GATE_EN_BIT] = gate_en;
   end

   always_comb begin
      rd_stat = 32'h0;
      rd_stat[ompg_pkg::STAT_REJECT_BIT]   = reject_flag;
      rd_stat[ompg_pkg::STAT_BUSY_BIT]     = busy;
      rd_stat[ompg_pkg::STAT_LCS_LSB +: 2] = lcs_i;
      rd_stat[ompg_pkg::STAT_DBG_LSB +: 2] = dbg_level_i;
   end

   wire [31:0] rd_lrej  = {28'h0, last_reject};
   wire [31:0] rd_acnt  = {16'h0, accept_count};
   wire [31:0] rd_rcnt  = {16'h0, reject_count};
   wire [31:0] rd_radr  = {16'h0, reject_addr};
   wire [31:0] rd_data  = hit_ctrl ? rd_ctrl :
                          hit_stat ? rd_stat :
                          hit_lrej ? rd_lrej :
                          hit_acnt ? rd_acnt :
                          hit_rcnt ? rd_rcnt :
                          hit_radr ? rd_radr : 32'h0;

   // one wait state answer; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_data : 32'h0;
      end
   end

   // gate enable: while low every command is refused
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_en <= ompg_pkg::CTRL_GATE_EN_RST;
      end else if (wr_ctrl) begin
         gate_en <= wb_dat_i[ompg_pkg::CTRL_GATE_EN_BIT];
      end
   end

   // sticky error: a new rejection wins over a clear in the same cycle
   wire next_reject_flag = reject_ev | (reject_flag & ~clr_rej);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reject_flag <= 1'b0;
      end else begin
         reject_flag <= next_reject_flag;
      end
   end

   // the error pin has a flop of its own, a copy of the flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         error_o <= 1'b0;
      end else begin
         error_o <= next_reject_flag;
      end
   end

   // rejected command packed at its named field positions
   logic [3:0] next_last_reject;

   always_comb begin
      next_last_reject = ompg_pkg::LREJ_RST;
      next_last_reject[ompg_pkg::LREJ_SRC_LSB +: 2] = cap_source;
      next_last_reject[ompg_pkg::LREJ_REGION_BIT]   = cap_region;
      next_last_reject[ompg_pkg::LREJ_ACCESS_BIT]   = cap_access;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_reject <= ompg_pkg::LREJ_RST;
         reject_addr <= '0;
      end else if (reject_ev) begin
         last_reject <= next_last_reject;
         reject_addr <= cap_addr;
      end
   end

endmodule // ompg_gate

//--- dv/ompg_seq_model.sv
// sequencer model that stalls its ready at random
`timescale 1ns/1ns
module ompg_seq_model (
   input  wire logic clk_i,
   input  wire logic seq_valid_i,
   output logic      seq_ready_o
);
   // ready follows the request one cycle late, and stalls it at random
   always @(posedge clk_i) begin
      seq_ready_o <= seq_valid_i && ($urandom_range(2) != 0);
   end
endmodule // ompg_seq_model

//--- dv/ompg_gate_checker.sv
// concurrent checks on the option memory program gate ports
`timescale 1ns/1ns
module ompg_gate_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cmd_valid_i,
   input wire logic        cmd_ready_o,
   input wire logic [1:0]  cmd_source_i,
   input wire logic        cmd_secure_region_i,
   input wire logic        cmd_secure_access_i,
   input wire logic [1:0]  lcs_i,
   input wire logic [1:0]  dbg_level_i,
   input wire logic        resp_valid_o,
   input wire logic        resp_error_o,
   input wire logic        seq_valid_o,
   input wire logic        seq_ready_i,
   input wire logic [15:0] seq_addr_o,
   input wire logic [31:0] seq_wdata_o,
   input wire logic        error_o,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire take = cmd_valid_i && cmd_ready_o;
   wire sec  = take && cmd_secure_region_i;
   sequence s_reject;
      !seq_valid_o [*3] ##0 (resp_valid_o && resp_error_o);
   endsequence
   property p_deny_self;
      sec && cmd_source_i == ompg_pkg::SRC_SELF && !cmd_secure_access_i
      |=> s_reject;
   endproperty
   property p_deny_ser;
      sec && cmd_source_i == ompg_pkg::SRC_SERIAL
      && lcs_i != ompg_pkg::LCS_SECURE_SOFTWARE_DEVELOPMENT |=> s_reject;
   endproperty
   property p_deny_dbg;
      sec && cmd_source_i == ompg_pkg::SRC_DEBUG
      && dbg_level_i != ompg_pkg::DBG_FULL_DEBUG_LEVEL |=> s_reject;
   endproperty
   property p_deny_bad;
      take && cmd_source_i == 2'h3 |=> s_reject;
   endproperty
   property p_err;
      resp_valid_o && resp_error_o |-> error_o;
   endproperty
   property p_acc;
      seq_valid_o && seq_ready_i
      |=> resp_valid_o && !resp_error_o && !seq_valid_o;
   endproperty
   property p_hold;
      seq_valid_o && !seq_ready_i
      |=> seq_valid_o && $stable(seq_addr_o) && $stable(seq_wdata_o);
   endproperty
   property p_busy;
      take |=> !cmd_ready_o;
   endproperty
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_deny_self: assert property (p_deny_self)
      else $error("self write to secure region passed");
   a_deny_ser: assert property (p_deny_ser)
      else $error("serial write to secure region passed");
   a_deny_dbg: assert property (p_deny_dbg)
      else $error("debugger write to secure region passed");
   a_deny_bad: assert property (p_deny_bad)
      else $error("unknown source passed");
   a_err: assert property (p_err)
      else $error("reject without error level");
   a_acc: assert property (p_acc)
      else $error("forwarded command not answered");
   a_hold: assert property (p_hold)
      else $error("sequencer request changed while stalled");
   a_busy: assert property (p_busy)
      else $error("ready stayed high after take");
   a_ack: assert property (p_ack)
      else $error("bus ack not a single cycle later");
endmodule // ompg_gate_checker

bind ompg_gate ompg_gate_checker u_chk (
   .clk_i               (clk_i),
   .rst_i               (rst_i),
   .cmd_valid_i         (cmd_valid_i),
   .cmd_ready_o         (cmd_ready_o),
   .cmd_source_i        (cmd_source_i),
   .cmd_secure_region_i (cmd_secure_region_i),
   .cmd_secure_access_i (cmd_secure_access_i),
   .lcs_i               (lcs_i),
   .dbg_level_i         (dbg_level_i),
   .resp_valid_o        (resp_valid_o),
   .resp_error_o        (resp_error_o),
   .seq_valid_o         (seq_valid_o),
   .seq_ready_i         (seq_ready_i),
   .seq_addr_o          (seq_addr_o),
   .seq_wdata_o         (seq_wdata_o),
   .error_o             (error_o),
   .wb_cyc_i            (wb_cyc_i),
   .wb_stb_i            (wb_stb_i),
   .wb_ack_o            (wb_ack_o)
);

//--- dv/tb.sv
// self-checking bench for the option memory program gate
`timescale 1ns/1ns
module tb;
   typedef struct packed {
      logic        err;
      logic        sreg;
      logic [15:0] addr;
      logic [31:0] data;
   } ompg_note_type;
   logic clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_ready_o;
   logic cmd_secure_region_i = 1'b0, cmd_secure_access_i = 1'b0;
   logic resp_valid_o, resp_error_o, seq_valid_o, seq_ready_i;
   logic seq_secure_region_o, error_o, wb_ack_o, wb_we_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic [1:0]  cmd_source_i = 2'h0, lcs_i = 2'h0, dbg_level_i = 2'h0;
   logic [3:0]  wb_sel_i = 4'hF, wb_sel_next = 4'hF;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [15:0] cmd_addr_i = 16'h0000, seq_addr_o, last_addr;
   logic [31:0] cmd_wdata_i = 32'h0, seq_wdata_o, wb_dat_i = 32'h0, wb_dat_o;
   int mismatches = 0, cmp_count = 0;
   ompg_note_type cq[$], cap, n;
   logic [31:0] wq[$];

   ompg_gate dut (
      .clk_i               (clk_i),
      .rst_i               (rst_i),
      .cmd_valid_i         (cmd_valid_i),
      .cmd_ready_o         (cmd_ready_o),
      .cmd_source_i        (cmd_source_i),
      .cmd_secure_region_i (cmd_secure_region_i),
      .cmd_secure_access_i (cmd_secure_access_i),
      .cmd_addr_i          (cmd_addr_i),
      .cmd_wdata_i         (cmd_wdata_i),
      .resp_valid_o        (resp_valid_o),
      .resp_error_o        (resp_error_o),
      .lcs_i               (lcs_i),
      .dbg_level_i         (dbg_level_i),
      .seq_valid_o         (seq_valid_o),
      .seq_ready_i         (seq_ready_i),
      .seq_secure_region_o (seq_secure_region_o),
      .seq_addr_o          (seq_addr_o),
      .seq_wdata_o         (seq_wdata_o),
      .error_o             (error_o),
      .wb_cyc_i            (wb_cyc_i),
      .wb_stb_i            (wb_stb_i),
      .wb_we_i             (wb_we_i),
      .wb_adr_i            (wb_adr_i),
      .wb_sel_i            (wb_sel_i),
      .wb_dat_i            (wb_dat_i),
      .wb_dat_o            (wb_dat_o),
      .wb_ack_o            (wb_ack_o)
   );
   ompg_seq_model seqm (.clk_i(clk_i), .seq_valid_i(seq_valid_o),
                        .seq_ready_o(seq_ready_i));

   initial forever #50 clk_i = ~clk_i;

   task automatic chk(input logic [63:0] got, exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_verdict(input logic got, exp);
      chk(got, exp, "verdict");
   endtask

   task automatic chk_fwd(input ompg_note_type got, exp);
      chk(got, exp, "forwarded");
   endtask

   task automatic chk_read(input logic [31:0] got, exp);
      chk(got, exp, "read data");
   endtask

   task automatic chk_level(input logic got, exp, input string m);
      chk(got, exp, m);
   endtask

   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      if (!we) wq.push_back(d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= wb_sel_next;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic cmd(input logic [1:0] s, input logic r, a, e);
      ompg_note_type x;
      x.err  = e;
      x.sreg = r;
      x.addr = 16'($urandom);
      x.data = $urandom;
      last_addr = x.addr;
      cq.push_back(x);
      @(posedge clk_i);
      cmd_source_i <= s;
      cmd_secure_region_i <= r;
      cmd_secure_access_i <= a;
      cmd_addr_i  <= x.addr;
      cmd_wdata_i <= x.data;
      cmd_valid_i <= 1'b1;
      do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
      cmd_valid_i <= 1'b0;
      do @(posedge clk_i); while (resp_valid_o !== 1'b1);
   endtask

   function automatic logic ok(input logic [1:0] s, l, d, input logic r, a);
      case (s)
         ompg_pkg::SRC_SELF: return !r || a;
         ompg_pkg::SRC_SERIAL:
            return l == ompg_pkg::LCS_SECURE_SOFTWARE_DEVELOPMENT || (!r
               && l == ompg_pkg::LCS_NONSECURE_SOFTWARE_DEVELOPMENT);
         ompg_pkg::SRC_DEBUG:
            return d == ompg_pkg::DBG_FULL_DEBUG_LEVEL || (!r
               && d == ompg_pkg::DBG_NONSECURE_DEBUG_LEVEL);
         default: return 1'b0;
      endcase
   endfunction

   // outcome of each command and each bus read, oldest note first
   always @(posedge clk_i) begin
      if (seq_valid_o && seq_ready_i)
         cap = {1'b0, seq_secure_region_o, seq_addr_o, seq_wdata_o};
      if (resp_valid_o === 1'b1 && cq.size() > 0) begin
         n = cq.pop_front();
         chk_verdict(resp_error_o, n.err);
         if (!n.err) chk_fwd(cap, n);
      end
      if (wb_ack_o === 1'b1 && !wb_we_i && wq.size() > 0)
         chk_read(wb_dat_o, wq.pop_front());
   end

   initial begin
      int acc;
      acc = 0;
      void'($urandom(32'h082D));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ompg_pkg::REG_CTRL, 32'h1);
      wb(1'b0, ompg_pkg::REG_ACCEPT_COUNT, 32'h0);
      wb(1'b0, 8'h20, 32'h0);
      $display("test reset values done");
      // every source, region, access, life-cycle and debug combination
      for (int i = 0; i < 256; i++) begin
         @(posedge clk_i);
         lcs_i <= i[5:4];
         dbg_level_i <= i[7:6];
         acc += ok(i[1:0], i[5:4], i[7:6], i[2], i[3]);
         cmd(i[1:0], i[2], i[3], !ok(i[1:0], i[5:4], i[7:6], i[2], i[3]));
      end
      wb(1'b0, ompg_pkg::REG_ACCEPT_COUNT, acc);
      wb(1'b0, ompg_pkg::REG_REJECT_COUNT, 256 - acc);
      wb(1'b0, ompg_pkg::REG_STATUS, 32'h3D);
      wb(1'b1, ompg_pkg::REG_STATUS, 32'h1);
      wb(1'b0, ompg_pkg::REG_STATUS, 32'h3C);
      chk_level(error_o, 1'b0, "error level cleared");
      $display("test permission table done");
      // gate off: a command that the state would allow is still refused
      @(posedge clk_i);
      lcs_i <= ompg_pkg::LCS_SECURE_SOFTWARE_DEVELOPMENT;
      // a write without byte lane 0 leaves the gate enabled
      wb_sel_next = 4'hE;
      wb(1'b1, ompg_pkg::REG_CTRL, 32'h0);
      wb_sel_next = 4'hF;
      wb(1'b0, ompg_pkg::REG_CTRL, 32'h1);
      wb(1'b1, ompg_pkg::REG_CTRL, 32'h0);
      cmd(ompg_pkg::SRC_SERIAL, 1'b1, 1'b1, 1'b1);
      chk_level(error_o, 1'b1, "error level set");
      wb(1'b0, ompg_pkg::REG_LAST_REJECT, 32'hD);
      wb(1'b0, ompg_pkg::REG_REJECT_ADDR, {16'h0, last_addr});
      wb(1'b1, ompg_pkg::REG_CTRL, 32'h3);
      wb(1'b0, ompg_pkg::REG_ACCEPT_COUNT, 32'h0);
      wb(1'b0, ompg_pkg::REG_CTRL, 32'h1);
      $display("test gate enable and registers done");
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      conclude();
   end
endmodule // tb
